// ---- include/dba_pkg.sv ----
/*
  Constants, enumerations and carriers for the debug pin acknowledge and abort block.
  Assumes all counts except ECHO_DEPTH, which is in I_CLK cycles, are in target serial clock ticks, one tick per enable pulse.
*/
package dba_pkg;

  localparam int unsigned CNT_W = 8;

  // Serial tick counts; the last tick index of each phase is count minus one, except MIN_GAP_TICKS, which gap_r must reach
  localparam logic [CNT_W-1:0] ACK_LOW_TICKS   = 8'h10;
  localparam logic [CNT_W-1:0] MIN_GAP_TICKS   = 8'h20;
  localparam logic [CNT_W-1:0] SYNC_THR_TICKS  = 8'h80;
  localparam logic [CNT_W-1:0] SYNC_DLY_TICKS  = 8'h10;
  localparam logic [CNT_W-1:0] SYNC_LOW_TICKS  = 8'h80;
  localparam logic [CNT_W-1:0] CNT_ONE         = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO        = 8'h00;

  // Cycles that a level driven by this block takes to come back through the synchroniser
  localparam int unsigned ECHO_DEPTH = 3;

  typedef enum logic [3:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_ACK_ON,
    CMD_ACK_OFF,
    CMD_HALT,
    CMD_RESUME,
    CMD_RESUME_UNTIL,
    CMD_STEP,
    CMD_OTHER
  } dba_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PEND,
    ST_ACK_LOW,
    ST_ACK_SPD,
    ST_SYNC_WAIT_HI,
    ST_SYNC_DLY,
    ST_SYNC_LOW,
    ST_SYNC_SPD
  } dba_state_e;

  // Command finished decoding: valid pulses at the last tick of the final bit
  typedef struct packed {
    logic     valid;
    dba_cmd_e kind;
  } dba_cmd_s;

  // Processor and bus events, one-cycle pulses except acc_busy
  typedef struct packed {
    logic bus_done;
    logic enter_soft_break_instr;
    logic leave_soft_break_instr;
    logic low_power;
    logic acc_busy;
  } dba_cpu_s;

endpackage

// ---- rtl/dba_ack_abort.sv ----
/*
  Acknowledge handshake and abort logic of the single-wire background debug port.
  Assumes a serial tick enable from a divider on I_CLK, a command decoder that reports
  each finished command, and an external pull-up on the open-drain debug pin.
*/
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Target starts acknowledge by pulling pin low
// - One acknowledged command outstanding at once
// - Wait or stop discards command, no acknowledge
// - Long abort runs reference response, cancels
// - Firmware access in progress completes, acknowledge suppressed
// - Resume, until-halt, step: only acknowledge suppressed
// - Short abort acts on perceived falling edge
// - Short abort cancels without reference response
// - After abort, next falling edge starts command
// - Handshake on/off by commands, off after reset
// - Handshake-on command itself is acknowledged
// - Read acknowledges after bus cycle completes
// - Write acknowledges after data and bus cycle
// - Halt acknowledges on entering background mode
// - Resume acknowledges on leaving background mode
// - Resume-until-halt acknowledges on next background entry
// - Single step acknowledges on return to background
// - Acknowledge: 16 cycles low, then speedup
// - Acknowledge starts at least 32 cycles after command
// - Reference response: 128 low, one-cycle speedup
// - Bits MSB first, 16 cycles, host falling edge
module dba_ack_abort (
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  input  wire logic              I_SER_TICK,
  input  wire logic              I_DBG_PIN_IN,
  input  wire dba_pkg::dba_cmd_s I_CMD,
  input  wire dba_pkg::dba_cpu_s I_CPU,
  output logic                   O_DBG_PIN_OUT,
  output logic                   O_DBG_PIN_OE,
  output logic                   O_HANDSHAKE_ON,
  output logic                   O_ACK_PENDING,
  output logic                   O_CMD_CANCEL,
  output logic                   O_FRESH_CMD
);
  import dba_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Event that completes each command kind
  function automatic logic ack_event(input dba_cmd_e k, input dba_cpu_s c);
    case (k)
      CMD_READ, CMD_WRITE:           ack_event = c.bus_done;
      CMD_ACK_ON:                    ack_event = 1'b1;
      CMD_HALT, CMD_RESUME_UNTIL,
      CMD_STEP:                      ack_event = c.enter_soft_break_instr;
      CMD_RESUME:                    ack_event = c.leave_soft_break_instr;
      default:                       ack_event = 1'b0;
    endcase
  endfunction

  // Whether an abort may cancel the command itself, not only its acknowledge
  function automatic logic can_cancel(input dba_cmd_e k, input dba_cpu_s c);
    case (k)
      CMD_RESUME, CMD_RESUME_UNTIL, CMD_STEP: can_cancel = 1'b0;
      CMD_READ, CMD_WRITE:                    can_cancel = ~c.acc_busy;
      default:                                can_cancel = 1'b1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and own-drive echo mask

  logic                  pin_s1_r;
  logic                  pin_s2_r;
  logic                  pin_d_r;
  logic [ECHO_DEPTH-1:0] echo_r;
  logic [ECHO_DEPTH-1:0] echo_nxt;
  logic                  mask;
  logic                  fall;

  always_comb begin
    echo_nxt = {echo_r[ECHO_DEPTH-2:0], O_DBG_PIN_OE};
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_d_r  <= 1'b1;
      echo_r   <= '0;
    end else begin
      pin_s1_r <= I_DBG_PIN_IN;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
      echo_r   <= echo_nxt;
    end
  end

  // Our own drive returns through the synchroniser; it must not look like the host
  assign mask = O_DBG_PIN_OE | (|echo_r);
  assign fall = pin_d_r & ~pin_s2_r & ~mask;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Handshake state machine

  dba_state_e             state_r;
  dba_state_e             state_nxt;
  logic [CNT_W-1:0]       cnt_r;
  logic [CNT_W-1:0]       cnt_nxt;
  logic [CNT_W-1:0]       gap_r;
  logic [CNT_W-1:0]       gap_nxt;
  logic [CNT_W-1:0]       low_r;
  logic [CNT_W-1:0]       low_nxt;
  dba_cmd_e               kind_r;
  dba_cmd_e               kind_nxt;
  logic                   ev_r;
  logic                   ev_nxt;
  logic                   on_nxt;
  logic                   fresh_r;
  logic                   fresh_nxt;
  logic                   cancel_nxt;
  logic                   fresh_out_nxt;
  logic                   out_nxt;
  logic                   oe_nxt;
  logic                   long_low;
  logic                   in_sync;

  assign in_sync  = (state_r == ST_SYNC_WAIT_HI) || (state_r == ST_SYNC_DLY) ||
                    (state_r == ST_SYNC_LOW) || (state_r == ST_SYNC_SPD);
  assign long_low = I_SER_TICK & ~pin_s2_r & ~mask & ~in_sync &
                    (low_r == SYNC_THR_TICKS - CNT_ONE);

  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    gap_nxt       = gap_r;
    kind_nxt      = kind_r;
    ev_nxt        = ev_r;
    on_nxt        = O_HANDSHAKE_ON;
    fresh_nxt     = fresh_r;
    cancel_nxt    = 1'b0;
    fresh_out_nxt = 1'b0;
    low_nxt       = low_r;
    // Low-time measurement of host pulses
    if (pin_s2_r || mask || in_sync) begin
      low_nxt = CNT_ZERO;
    end else if (I_SER_TICK && (low_r != SYNC_THR_TICKS)) begin
      low_nxt = low_r + CNT_ONE;
    end
    // First host edge after an abort opens a new command
    if (fall && fresh_r) begin
      fresh_nxt     = 1'b0;
      fresh_out_nxt = 1'b1;
    end
    case (state_r)
      ST_IDLE: begin
        if (I_CMD.valid && !I_CPU.low_power) begin
          if (I_CMD.kind == CMD_ACK_ON) begin
            on_nxt = 1'b1;
          end else if (I_CMD.kind == CMD_ACK_OFF) begin
            on_nxt = 1'b0;
          end
          if ((O_HANDSHAKE_ON || I_CMD.kind == CMD_ACK_ON) &&
              I_CMD.kind != CMD_ACK_OFF && I_CMD.kind != CMD_OTHER) begin
            state_nxt = ST_PEND;
            kind_nxt  = I_CMD.kind;
            ev_nxt    = ack_event(I_CMD.kind, I_CPU);
            gap_nxt   = CNT_ZERO;
          end
        end
      end
      ST_PEND: begin
        if (I_SER_TICK && gap_r != MIN_GAP_TICKS) begin
          gap_nxt = gap_r + CNT_ONE;
        end
        ev_nxt = ev_r | ack_event(kind_r, I_CPU);
        if (I_CPU.low_power && !ev_r) begin
          state_nxt = ST_IDLE;
        end else if (fall) begin
          state_nxt  = ST_IDLE;
          cancel_nxt = can_cancel(kind_r, I_CPU);
          fresh_nxt  = 1'b1;
        end else if (ev_r && gap_r == MIN_GAP_TICKS) begin
          state_nxt = ST_ACK_LOW;
          cnt_nxt   = CNT_ZERO;
        end
      end
      ST_ACK_LOW: begin
        if (I_SER_TICK) begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == ACK_LOW_TICKS - CNT_ONE) begin
            state_nxt = ST_ACK_SPD;
          end
        end
      end
      ST_ACK_SPD: begin
        if (I_SER_TICK) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SYNC_WAIT_HI: begin
        // No timeout here: a pin held low keeps the response waiting
        if (pin_s2_r) begin
          state_nxt = ST_SYNC_DLY;
          cnt_nxt   = CNT_ZERO;
        end
      end
      ST_SYNC_DLY: begin
        if (I_SER_TICK) begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == SYNC_DLY_TICKS - CNT_ONE) begin
            state_nxt = ST_SYNC_LOW;
            cnt_nxt   = CNT_ZERO;
          end
        end
      end
      ST_SYNC_LOW: begin
        if (I_SER_TICK) begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == SYNC_LOW_TICKS - CNT_ONE) begin
            state_nxt = ST_SYNC_SPD;
          end
        end
      end
      ST_SYNC_SPD: begin
        if (I_SER_TICK) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Long low overrides all; it cancels unless fresh_r shows its opening edge already settled the cancel or the pending command cannot be cancelled
    if (long_low) begin
      state_nxt  = ST_SYNC_WAIT_HI;
      cancel_nxt = !fresh_r && ((state_r != ST_PEND) || can_cancel(kind_r, I_CPU));
      fresh_nxt  = 1'b1;
    end
    out_nxt = (state_nxt == ST_ACK_SPD) || (state_nxt == ST_SYNC_SPD);
    oe_nxt  = (state_nxt == ST_ACK_LOW) || (state_nxt == ST_ACK_SPD) ||
              (state_nxt == ST_SYNC_LOW) || (state_nxt == ST_SYNC_SPD);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r        <= ST_IDLE;
      cnt_r          <= CNT_ZERO;
      gap_r          <= CNT_ZERO;
      low_r          <= CNT_ZERO;
      kind_r         <= CMD_OTHER;
      ev_r           <= 1'b0;
      fresh_r        <= 1'b0;
      O_HANDSHAKE_ON <= 1'b0;
      O_ACK_PENDING  <= 1'b0;
      O_CMD_CANCEL   <= 1'b0;
      O_FRESH_CMD    <= 1'b0;
      O_DBG_PIN_OUT  <= 1'b0;
      O_DBG_PIN_OE   <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      cnt_r          <= cnt_nxt;
      gap_r          <= gap_nxt;
      low_r          <= low_nxt;
      kind_r         <= kind_nxt;
      ev_r           <= ev_nxt;
      fresh_r        <= fresh_nxt;
      O_HANDSHAKE_ON <= on_nxt;
      O_ACK_PENDING  <= (state_nxt == ST_PEND);
      O_CMD_CANCEL   <= cancel_nxt;
      O_FRESH_CMD    <= fresh_out_nxt;
      O_DBG_PIN_OUT  <= out_nxt;
      O_DBG_PIN_OE   <= oe_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence ack_start_s;
    (state_r == ST_PEND) ##1 (state_r == ST_ACK_LOW);
  endsequence

  sequence ack_end_s;
    (state_r == ST_ACK_LOW && I_SER_TICK && cnt_r == ACK_LOW_TICKS - CNT_ONE);
  endsequence

  ack_low_drive_a: assert property ((state_r == ST_ACK_LOW) |-> (O_DBG_PIN_OE && !O_DBG_PIN_OUT))
    else $error("acknowledge low phase not driving the pin low");

  ack_gap_a: assert property (ack_start_s |-> ($past(gap_r, 1) == MIN_GAP_TICKS))
    else $error("acknowledge started before the minimum gap");

  ack_length_a: assert property (ack_end_s |=> (state_r == ST_ACK_SPD && O_DBG_PIN_OUT))
    else $error("acknowledge low phase length wrong");

  sync_length_a: assert property ((state_r == ST_SYNC_LOW && I_SER_TICK &&
                                   cnt_r == SYNC_LOW_TICKS - CNT_ONE)
                                  |=> (state_r == ST_SYNC_SPD && O_DBG_PIN_OE && O_DBG_PIN_OUT))
    else $error("reference response low length wrong");

  long_abort_a: assert property (long_low |=> (state_r == ST_SYNC_WAIT_HI && O_CMD_CANCEL ==
                                 (!$past(fresh_r) && (($past(state_r) != ST_PEND) ||
                                  can_cancel($past(kind_r), $past(I_CPU))))))
    else $error("long low pulse not turned into reference response");

  short_abort_a: assert property ((state_r == ST_PEND && fall && !I_CPU.low_power && !long_low)
                                  |=> (state_r == ST_IDLE && !O_DBG_PIN_OE))
    else $error("short abort did not cancel the pending acknowledge");

  no_cancel_run_a: assert property ((state_r == ST_PEND && fall &&
                                     (kind_r == CMD_STEP || kind_r == CMD_RESUME))
                                    |=> !O_CMD_CANCEL)
    else $error("uncancellable command was cancelled");

  lowpwr_drop_a: assert property ((state_r == ST_PEND && I_CPU.low_power && !ev_r && !long_low)
                                  |=> ##[0:2] (!O_DBG_PIN_OE && state_r != ST_ACK_LOW))
    else $error("discarded command still acknowledged");

  hs_off_a: assert property ((O_HANDSHAKE_ON == 1'b0 && state_r == ST_IDLE && I_CMD.valid &&
                              I_CMD.kind == CMD_READ) |=> (state_r != ST_PEND))
    else $error("read pending while handshake is off");

  fresh_edge_a: assert property ((fresh_r && fall) |=> (O_FRESH_CMD && !fresh_r))
    else $error("first edge after abort not flagged");

endmodule // dba_ack_abort

// ---- tb/dba_ack_abort_tb.sv ----
/*
  Self-checking bench for the acknowledge and abort block with a host model on the pin.
  Assumes a serial tick every clock cycle, so tick counts equal clock cycles.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  checks++; \
  if ((ex) !== (got)) begin \
    err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
  end \
end

module dba_ack_abort_tb;
  import dba_pkg::*;
  logic     clk   = 1'b0;
  logic     rst_n = 1'b0;
  logic     tick  = 1'b1;
  dba_cmd_s cmd   = '0;
  dba_cpu_s cpu   = '0;
  logic     pin, pin_out, pin_oe, hs_on, pend, cancel, fresh, clash;
  int       err_count = 0;
  int       checks    = 0;
  int       n_cancel  = 0;
  int       n_fresh   = 0;
  int       n_oe      = 0;

  always #2 clk = ~clk;

  dba_ack_abort dba_ack_abort_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_SER_TICK(tick),
    .I_DBG_PIN_IN(pin), .I_CMD(cmd), .I_CPU(cpu), .O_DBG_PIN_OUT(pin_out),
    .O_DBG_PIN_OE(pin_oe), .O_HANDSHAKE_ON(hs_on), .O_ACK_PENDING(pend),
    .O_CMD_CANCEL(cancel), .O_FRESH_CMD(fresh));
  dba_host_model dba_host_model_inst (.clk(clk), .i_oe(pin_oe), .i_out(pin_out),
    .o_pin(pin), .o_clash(clash));

  always @(posedge clk) begin
    if (cancel === 1'b1) n_cancel++;
    if (fresh === 1'b1) n_fresh++;
    if (pin_oe === 1'b1) n_oe++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send(input dba_cmd_e k);
    @(posedge clk);
    cmd <= '{valid: 1'b1, kind: k};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
  endtask

  task automatic ev(input int b);
    @(posedge clk);
    cpu[b] <= 1'b1;
    @(posedge clk);
    cpu[b] <= 1'b0;
    #1;
  endtask

  // Bounded waits: a missing pulse shows as a wrong length, not a hang
  task automatic ack_pulse(input int low_exp, output int gap);
    int lo;
    int sp;
    gap = 0;
    lo = 0;
    sp = 0;
    while (pin_oe !== 1'b1 && gap < 400) begin gap++; cyc(1); end
    while (pin_oe === 1'b1 && pin_out === 1'b0 && lo < 400) begin lo++; cyc(1); end
    while (pin_oe === 1'b1 && pin_out === 1'b1 && sp < 400) begin sp++; cyc(1); end
    `CHK("low_len", low_exp, lo)
    `CHK("speedup", 1, sp)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_off;
    `CHK("hs_reset", 1'b0, hs_on)
    send(CMD_READ);
    cyc(40);
    `CHK("pend_off", 1'b0, pend)
    `CHK("oe_off", 0, n_oe)
  endtask

  task automatic t_ack_on;
    int gap;
    send(CMD_ACK_ON);
    `CHK("hs_on", 1'b1, hs_on)
    `CHK("pend_on", 1'b1, pend)
    ack_pulse(16, gap);
    `CHK("gap_min", 1'b1, gap >= 32)
  endtask

  // Each command waits for its own completion event only
  task automatic t_events;
    dba_cmd_e k[6] = '{CMD_READ, CMD_WRITE, CMD_HALT, CMD_RESUME, CMD_RESUME_UNTIL, CMD_STEP};
    int       b[6] = '{4, 4, 3, 2, 3, 3};
    int       o;
    int       gap;
    foreach (k[i]) begin
      o = n_oe;
      send(k[i]);
      cyc(40);
      `CHK("no_early", o, n_oe)
      `CHK("pend_ev", 1'b1, pend)
      ev(b[i]);
      ack_pulse(16, gap);
    end
  endtask

  task automatic t_low_power;
    int o;
    o = n_oe;
    send(CMD_WRITE);
    ev(1);
    ev(4);
    cyc(50);
    `CHK("lp_pend", 1'b0, pend)
    `CHK("lp_no_ack", o, n_oe)
  endtask

  // Host aborts instead of issuing a new command while one is pending
  task automatic t_aborts;
    dba_cmd_e k[5]  = '{CMD_READ, CMD_STEP, CMD_RESUME, CMD_WRITE, CMD_HALT};
    bit       bz[5] = '{0, 0, 0, 1, 0};
    bit       lg[5] = '{0, 0, 1, 1, 1};
    int       ex[5] = '{1, 0, 0, 0, 1};
    int       c;
    int       f;
    int       gap;
    foreach (k[i]) begin
      send(k[i]);
      @(posedge clk);
      cpu.acc_busy <= bz[i];
      cyc(5);
      c = n_cancel;
      if (lg[i]) begin
        dba_host_model_inst.pulse_low(130);
        ack_pulse(128, gap);
      end else begin
        dba_host_model_inst.pulse_low(6);
        cyc(10);
        `CHK("short_no_ack", 1'b0, pin_oe)
      end
      `CHK("cancel", ex[i], n_cancel - c)
      `CHK("pend_abort", 1'b0, pend)
      @(posedge clk);
      cpu.acc_busy <= 1'b0;
      cyc(10);
      f = n_fresh;
      dba_host_model_inst.pulse_low(6);
      cyc(10);
      `CHK("fresh", 1, n_fresh - f)
    end
  endtask

  task automatic t_ack_off;
    send(CMD_ACK_OFF);
    `CHK("hs_off", 1'b0, hs_on)
    send(CMD_HALT);
    cyc(40);
    `CHK("pend_hs_off", 1'b0, pend)
    `CHK("no_clash", 1'b0, clash)
  endtask

  // Reset in mid-run cuts a running acknowledge and turns the handshake off
  task automatic t_mid_reset;
    send(CMD_ACK_ON);
    cyc(36);
    `CHK("hs_before_rst", 1'b1, hs_on)
    `CHK("oe_before_rst", 1'b1, pin_oe)
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(3);
    `CHK("rst_oe", 1'b0, pin_oe)
    `CHK("rst_pend", 1'b0, pend)
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    `CHK("hs_mid_rst", 1'b0, hs_on)
    send(CMD_READ);
    cyc(40);
    `CHK("pend_mid_rst", 1'b0, pend)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run needs under two thousand cycles; the limit leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    t_reset_off();
    t_ack_on();
    t_events();
    t_low_power();
    t_aborts();
    t_ack_off();
    t_mid_reset();
    give_verdict();
  end
endmodule // dba_ack_abort_tb

// ---- tb/dba_host_model.sv ----
/*
  Behavioural model of the host adapter that shares the open-drain debug pin.
  Assumes the pin has a pull-up, so a released wire reads high.
*/
`timescale 1ns/100ps

module dba_host_model (
  input  wire logic clk,
  input  wire logic i_oe,
  input  wire logic i_out,
  output logic      o_pin,
  output logic      o_clash
);
  logic host_lo = 1'b0;
  logic host_hi = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Wire: any low drive wins, otherwise the pull-up or a speedup holds it high
  assign o_pin = ((i_oe && !i_out) || host_lo) ? 1'b0 : 1'b1;

  // Speedup while the target pulls low would be contention
  initial o_clash = 1'b0;
  always @(posedge clk) begin
    if (host_hi && i_oe && !i_out) begin
      o_clash <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Low pulse of n cycles, then a one-cycle speedup, then release
  task automatic pulse_low(input int n);
    @(posedge clk);
    host_lo <= 1'b1;
    repeat (n) @(posedge clk);
    host_lo <= 1'b0;
    host_hi <= 1'b1;
    @(posedge clk);
    host_hi <= 1'b0;
  endtask
endmodule // dba_host_model
